// ---- fcsw_link_if.sv ----
// Carrier between the status word top and its link-up timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface fcsw_link_if;
  logic conn_on; // Filtered connection status
  logic in_en; // Remote inputs may be accepted
  logic out_en; // Remote outputs may be updated
  modport timer (input conn_on, output in_en, output out_en);
  modport user (output conn_on, input in_en, input out_en);
endinterface

// ---- fcsw_link_timer.sv ----
// Link-up timer: opens the remote input and output paths after connection turns on.
// Assumes conn_on is already synchronised and filtered by the caller.
`timescale 1ns/100ps
module fcsw_link_timer
  import fcsw_pkg::*;
#(
  parameter int P_IN_CYC = MASTER_CYCLE_CYC + SERIAL_CYCLE_CYC,
  parameter int P_OUT_CYC = 2 * (MASTER_CYCLE_CYC + SERIAL_CYCLE_CYC)
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  fcsw_link_if.timer link
);
  localparam int CW = $clog2(P_OUT_CYC + 1);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (P_IN_CYC < 1 || P_OUT_CYC < P_IN_CYC) begin : g_bad_par
    $error("Link timer delays must be positive and ordered");
  end

  logic [CW-1:0] cnt_r; // Cycles since connection turned on
  logic [CW-1:0] cnt_nxt;
  logic in_en_r; // Input path open
  logic in_en_nxt;
  logic out_en_r; // Output path open
  logic out_en_nxt;

  // Count while connected, saturate at the output delay, restart on drop
  always_comb begin
    cnt_nxt = cnt_r;
    if (!link.conn_on) begin
      cnt_nxt = '0;
    end else if (cnt_r != CW'(P_OUT_CYC)) begin
      cnt_nxt = cnt_r + CW'(1);
    end
    in_en_nxt = link.conn_on && (cnt_nxt >= CW'(P_IN_CYC));
    out_en_nxt = link.conn_on && (cnt_nxt >= CW'(P_OUT_CYC));
  end

  // Register stage
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_r <= '0;
      in_en_r <= 1'b0;
      out_en_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_en_r <= in_en_nxt;
      out_en_r <= out_en_nxt;
    end
  end

  assign link.in_en = in_en_r;
  assign link.out_en = out_en_r;
endmodule

// ---- fcsw_master_model.sv ----
// Master station model: turns a command control word into frame fields.
// Assumes the bench changes its inputs just after a clock edge.
`timescale 1ns/100ps
module fcsw_master_model (
  input wire logic i_send, // Bench asks for one frame
  input wire logic [15:0] i_ctrl_word, // Control word to send
  input wire logic [15:0] i_rio_want, // Remote inputs wanted
  input wire logic i_connected, // Connection status from device
  output logic o_frame_valid, // Frame strobe
  output logic [1:0] o_command_tag, // Tag carried in the frame
  output logic o_fault_clear_request, // Clear request bit
  output logic [15:0] o_rio_in // Remote inputs sent
);
  // ----------------------------------------
  // Frame fields
  // ----------------------------------------
  assign o_frame_valid = i_send;
  assign o_command_tag = i_ctrl_word[7:6];
  assign o_fault_clear_request = i_ctrl_word[3];
  // Start and homing bits kept off so nothing moves on reconnect
  assign o_rio_in = i_connected ? i_rio_want : {i_rio_want[15:2], 2'h0};
endmodule

// ---- fcsw_pkg.sv ----
// Constants shared by the command status word block and its link-up timer.
// Assumes a single 250 MHz system clock feeding every module that imports it.
package fcsw_pkg;
  // ------------------------------------------------------------
  // Clock and cycle times
  // ------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 4; // 250 MHz system clock
  localparam int MASTER_CYCLE_TIME_NS = 1000; // Master cycle, plain default
  localparam int SERIAL_CYCLE_TIME_NS = 1000; // Serial cycle, plain default
  // Least times round up to whole clock cycles
  localparam int MASTER_CYCLE_CYC = (MASTER_CYCLE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SERIAL_CYCLE_CYC = (SERIAL_CYCLE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int FAULT_CLEAR_CYC = 4; // Length of the internal clearing process

  // ------------------------------------------------------------
  // Status word field layout
  // ------------------------------------------------------------
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_WARNING_BIT = 1;
  localparam int ST_ACCEPT_BIT = 2;
  localparam int ST_CLEAR_DONE_BIT = 3;
  localparam int ST_RSVD_LO = 4;
  localparam int ST_RSVD_HI = 5;
  localparam int ST_TAG_LO = 6;
  localparam int ST_TAG_HI = 7;
  localparam int ST_CMD_ERR_LO = 8;
  localparam int ST_CMD_ERR_HI = 11;
  localparam int ST_LINK_ERR_LO = 12;
  localparam int ST_LINK_ERR_HI = 15;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0] TAG_RESET = 2'h0;
  localparam logic [3:0] ERR_CODE_RESET = 4'h0;
  localparam logic [1:0] STATUS_RSVD_VALUE = 2'h0;

  // Fault clear sequence states, one-hot
  typedef enum logic [2:0] {
    FCSW_CLR_IDLE = 3'b001,
    FCSW_CLR_BUSY = 3'b010,
    FCSW_CLR_DONE = 3'b100
  } fcsw_clr_state_t;
endpackage

// ---- fcsw_status_word.sv ----
// Command status word generator for a fieldbus to serial converter slave.
// Assumes a frame decoder on the system clock delivers command bits and events;
// only the connection status arrives from outside the clock domain.
`timescale 1ns/100ps
// How it works
// - Own alarm sets alarm flag bit 0
// - Alarm-clear command returns alarm flag to 0
// - Own warning sets warning flag bit 1
// - Alarm-clear command returns warning flag to 0
// - Bit 2 shows whether a command is acceptable
// - Disconnect runs at once regardless of bit 2
// - Clear-done set after request seen and clearing finished
// - Request dropping to 0 clears clear-done
// - Bits 6-7 echo the command tag
// - Command error field, cleared by next valid command
// - Link error field, cleared by request edge or clear command
// - Inputs open after TM+TS, outputs after twice that
module fcsw_status_word
  import fcsw_pkg::*;
#(
  parameter int P_RIO_W = 16,
  parameter int P_IN_CYC = MASTER_CYCLE_CYC + SERIAL_CYCLE_CYC,
  parameter int P_OUT_CYC = 2 * (MASTER_CYCLE_CYC + SERIAL_CYCLE_CYC),
  parameter int P_CLEAR_CYC = FAULT_CLEAR_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_alarm_event, // Own alarm occurred, pulse
  input wire logic i_warning_event, // Own warning occurred, pulse
  input wire logic i_alarm_clear_cmd, // Alarm-clear command executed, pulse
  input wire logic i_cmd_busy, // Command processing in progress, level
  input wire logic i_disconnect_cmd, // Disconnect command received, pulse
  input wire logic i_frame_valid, // Command frame received, pulse
  input wire logic [1:0] i_command_tag, // Tag field of the frame
  input wire logic i_fault_clear_request, // Control word clear request bit
  input wire logic i_cmd_valid, // Valid command received, pulse
  input wire logic i_cmd_error_event, // Command error detected, pulse
  input wire logic [3:0] i_cmd_error_code, // Code for that error
  input wire logic i_link_error_event, // Link error detected, pulse
  input wire logic [3:0] i_link_error_code, // Code for that error
  input wire logic i_connection_on, // Connection status pin, asynchronous
  input wire logic [P_RIO_W-1:0] i_rio_in, // Remote inputs from master
  input wire logic [P_RIO_W-1:0] i_rio_out_src, // Remote outputs from product
  output logic [15:0] o_status_word, // Status word for the response
  output logic o_disconnect_exec, // Disconnect executed, pulse
  output logic o_connected, // Filtered connection status
  output logic [P_RIO_W-1:0] o_rio_in, // Accepted remote inputs
  output logic [P_RIO_W-1:0] o_rio_out // Remote outputs towards master
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (P_RIO_W < 1 || P_CLEAR_CYC < 1) begin : g_bad_par
    $error("Remote width and clear length must be positive");
  end

  localparam int CCW = $clog2(P_CLEAR_CYC + 1);

  // Set wins over clear; a fresh event also loads its code
  function automatic logic [3:0] err_next(input logic [3:0] cur, input logic set,
                                          input logic [3:0] code, input logic clr);
    logic [3:0] r;
    r = cur;
    if (set) begin
      r = code;
    end else if (clr) begin
      r = ERR_CODE_RESET;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Connection status synchroniser
  // ------------------------------------------------------------
  logic [2:0] sync_r; // Three-stage chain, stage 0 read only by stage 1
  logic [2:0] sync_nxt;
  logic conn_r; // Filtered level
  logic conn_nxt;

  // Change is taken once stages 1 and 2 agree
  always_comb begin
    sync_nxt = {sync_r[1:0], i_connection_on};
    conn_nxt = conn_r;
    if (sync_r[1] == sync_r[2]) begin
      conn_nxt = sync_r[2];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sync_r <= 3'h0;
      conn_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      conn_r <= conn_nxt;
    end
  end

  // ------------------------------------------------------------
  // Link-up timer
  // ------------------------------------------------------------
  fcsw_link_if link ();
  assign link.conn_on = conn_r;

  fcsw_link_timer #(
    .P_IN_CYC(P_IN_CYC),
    .P_OUT_CYC(P_OUT_CYC)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .link(link)
  );

  // ------------------------------------------------------------
  // Fault clear sequence
  // ------------------------------------------------------------
  fcsw_clr_state_t clr_r; // Clear sequence state
  fcsw_clr_state_t clr_nxt;
  logic [CCW-1:0] ccnt_r; // Clearing progress
  logic [CCW-1:0] ccnt_nxt;
  logic req_d_r; // Request seen last cycle, for edge detect
  logic req_rise;
  logic clr_finish; // Clearing process completes this cycle

  assign req_rise = i_fault_clear_request && !req_d_r;

  // Idle -> busy on request, busy -> done after the clear length,
  // done -> idle once the master drops the request
  always_comb begin
    clr_nxt = clr_r;
    ccnt_nxt = ccnt_r;
    clr_finish = 1'b0;
    unique case (clr_r)
      FCSW_CLR_IDLE: begin
        ccnt_nxt = '0;
        if (i_fault_clear_request) begin
          clr_nxt = FCSW_CLR_BUSY;
        end
      end
      FCSW_CLR_BUSY: begin
        if (!i_fault_clear_request) begin
          // Request withdrawn before completion: abandon quietly
          clr_nxt = FCSW_CLR_IDLE;
        end else if (ccnt_r == CCW'(P_CLEAR_CYC - 1)) begin
          clr_finish = 1'b1;
          clr_nxt = FCSW_CLR_DONE;
        end else begin
          ccnt_nxt = ccnt_r + CCW'(1);
        end
      end
      FCSW_CLR_DONE: begin
        if (!i_fault_clear_request) begin
          clr_nxt = FCSW_CLR_IDLE;
        end
      end
      default: begin
        // Illegal code recovers to idle
        clr_nxt = FCSW_CLR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      clr_r <= FCSW_CLR_IDLE;
      ccnt_r <= '0;
      req_d_r <= 1'b0;
    end else begin
      clr_r <= clr_nxt;
      ccnt_r <= ccnt_nxt;
      req_d_r <= i_fault_clear_request;
    end
  end

  // ------------------------------------------------------------
  // Status flags and fields
  // ------------------------------------------------------------
  logic alarm_r; // Own alarm flag
  logic alarm_nxt;
  logic warn_r; // Own warning flag
  logic warn_nxt;
  logic [1:0] tag_r; // Echoed tag
  logic [1:0] tag_nxt;
  logic [3:0] cmd_err_r; // Command error code
  logic [3:0] cmd_err_nxt;
  logic [3:0] link_err_r; // Link error code
  logic [3:0] link_err_nxt;
  logic disc_r; // Disconnect executed pulse
  logic disc_nxt;
  logic fault_clear; // Any clearing of alarm and warning this cycle

  // A fresh alarm in the clearing cycle stays set, so nothing is lost
  always_comb begin
    fault_clear = i_alarm_clear_cmd || clr_finish;
    alarm_nxt = alarm_r;
    if (i_alarm_event) begin
      alarm_nxt = 1'b1;
    end else if (fault_clear) begin
      alarm_nxt = 1'b0;
    end
    warn_nxt = warn_r;
    if (i_warning_event) begin
      warn_nxt = 1'b1;
    end else if (fault_clear) begin
      warn_nxt = 1'b0;
    end
    tag_nxt = i_frame_valid ? i_command_tag : tag_r;
    cmd_err_nxt = err_next(cmd_err_r, i_cmd_error_event, i_cmd_error_code, i_cmd_valid);
    // Only the rising edge clears, so a held request cannot mask new errors
    link_err_nxt = err_next(link_err_r, i_link_error_event, i_link_error_code,
                            req_rise || i_alarm_clear_cmd);
    disc_nxt = i_disconnect_cmd;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      alarm_r <= 1'b0;
      warn_r <= 1'b0;
      tag_r <= TAG_RESET;
      cmd_err_r <= ERR_CODE_RESET;
      link_err_r <= ERR_CODE_RESET;
      disc_r <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
      warn_r <= warn_nxt;
      tag_r <= tag_nxt;
      cmd_err_r <= cmd_err_nxt;
      link_err_r <= link_err_nxt;
      disc_r <= disc_nxt;
    end
  end

  // ------------------------------------------------------------
  // Remote I/O gating
  // ------------------------------------------------------------
  logic [P_RIO_W-1:0] rin_r; // Accepted inputs
  logic [P_RIO_W-1:0] rin_nxt;
  logic [P_RIO_W-1:0] rout_r; // Outputs towards master
  logic [P_RIO_W-1:0] rout_nxt;

  // Disabled inputs read as off; stopped outputs keep their last value.
  // The master is trusted to drive start inputs off while disconnected.
  always_comb begin
    rin_nxt = link.in_en ? i_rio_in : '0;
    rout_nxt = link.out_en ? i_rio_out_src : rout_r;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rin_r <= '0;
      rout_r <= '0;
    end else begin
      rin_r <= rin_nxt;
      rout_r <= rout_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    o_status_word = 16'h0000;
    o_status_word[ST_ALARM_BIT] = alarm_r;
    o_status_word[ST_WARNING_BIT] = warn_r;
    o_status_word[ST_ACCEPT_BIT] = !i_cmd_busy;
    o_status_word[ST_CLEAR_DONE_BIT] = (clr_r == FCSW_CLR_DONE);
    o_status_word[ST_RSVD_HI:ST_RSVD_LO] = STATUS_RSVD_VALUE;
    o_status_word[ST_TAG_HI:ST_TAG_LO] = tag_r;
    o_status_word[ST_CMD_ERR_HI:ST_CMD_ERR_LO] = cmd_err_r;
    o_status_word[ST_LINK_ERR_HI:ST_LINK_ERR_LO] = link_err_r;
  end

  assign o_disconnect_exec = disc_r;
  assign o_connected = conn_r;
  assign o_rio_in = rin_r;
  assign o_rio_out = rout_r;
endmodule

// ---- fcsw_status_word_chk.sv ----
// Concurrent checks on the command status word block, attached by bind.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/100ps
module fcsw_status_word_chk #(
  parameter int P_RIO_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_alarm_event,
  input wire logic i_warning_event,
  input wire logic i_alarm_clear_cmd,
  input wire logic i_cmd_busy,
  input wire logic i_disconnect_cmd,
  input wire logic i_frame_valid,
  input wire logic [1:0] i_command_tag,
  input wire logic i_fault_clear_request,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_error_event,
  input wire logic [3:0] i_cmd_error_code,
  input wire logic i_link_error_event,
  input wire logic [3:0] i_link_error_code,
  input wire logic [15:0] o_status_word,
  input wire logic o_disconnect_exec,
  input wire logic o_connected,
  input wire logic [P_RIO_W-1:0] o_rio_in,
  input wire logic [P_RIO_W-1:0] o_rio_out
);
  // ----------------------------------------
  // Clocking and step sequences
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Request rises and stays long enough for clearing to end
  sequence s_req_held;
    !i_fault_clear_request ##1 i_fault_clear_request[*6];
  endsequence
  // Connection seen off long enough for both paths to close
  sequence s_link_closed;
    !o_connected[*3];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_alarm_set: assert property (i_alarm_event |=> o_status_word[0]) else $error("alarm flag not set");
  a_alarm_clear: assert property (i_alarm_clear_cmd && !i_alarm_event |=> !o_status_word[0])
    else $error("alarm flag not cleared");
  a_warn_set: assert property (i_warning_event |=> o_status_word[1]) else $error("warning flag not set");
  a_warn_clear: assert property (i_alarm_clear_cmd && !i_warning_event |=> !o_status_word[1])
    else $error("warning flag not cleared");
  a_accept_flag: assert property (o_status_word[2] == !i_cmd_busy) else $error("accept flag wrong");
  a_disc_exec: assert property (i_disconnect_cmd |=> o_disconnect_exec) else $error("disconnect not run");
  a_done_cause: assert property ($rose(o_status_word[3]) |-> $past(i_fault_clear_request, 5))
    else $error("clear done without request");
  a_done_reach: assert property (s_req_held |-> o_status_word[3]) else $error("clear done late");
  a_done_drop: assert property (!i_fault_clear_request |=> !o_status_word[3]) else $error("clear done stuck");
  a_tag_echo: assert property (i_frame_valid |=> o_status_word[7:6] == $past(i_command_tag))
    else $error("tag echo wrong");
  a_cmd_err: assert property (i_cmd_error_event |=> o_status_word[11:8] == $past(i_cmd_error_code))
    else $error("command error code wrong");
  a_cmd_clear: assert property (i_cmd_valid && !i_cmd_error_event |=> o_status_word[11:8] == 4'h0)
    else $error("command error not cleared");
  a_link_err: assert property (i_link_error_event |=> o_status_word[15:12] == $past(i_link_error_code))
    else $error("link error code wrong");
  a_link_clear: assert property (($rose(i_fault_clear_request) || i_alarm_clear_cmd) && !i_link_error_event
    |=> o_status_word[15:12] == 4'h0) else $error("link error not cleared");
  a_rsvd_zero: assert property (o_status_word[5:4] == 2'h0) else $error("reserved bits set");
  a_in_closed: assert property (s_link_closed |-> o_rio_in == '0) else $error("inputs not closed");
  a_out_held: assert property (s_link_closed |=> $stable(o_rio_out)) else $error("outputs not held");
endmodule

bind fcsw_status_word fcsw_status_word_chk #(.P_RIO_W(P_RIO_W)) u_chk (.*);

// ---- tb_fcsw_status_word.sv ----
// Self-checking bench for the command status word block.
// Assumes the checker is bound in and short link-up counts are set here.
`timescale 1ns/100ps
module tb_fcsw_status_word;
  import fcsw_pkg::*;
  localparam int P_IN = 3; // Shortened input opening count
  localparam int P_OUT = 6; // Shortened output opening count
  localparam int CLR = 4; // Clearing process length
  // Event bits: alarm, warning, clear, frame, cmd err, valid, link err
  typedef struct packed {logic [6:0] ev; logic [1:0] tag; logic [3:0] code; logic [15:0] exp;} fcsw_row_t;
  logic clk = 1'b0, rst = 1'b1, busy = 1'b0, disc = 1'b0, send = 1'b0, pin = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [3:0] code = 4'h0;
  logic [15:0] ctrl = 16'h0000, want = 16'hFFFF, src = 16'hA5A5;
  logic fv, freq, conn, dx;
  logic [1:0] tag;
  logic [15:0] sw, rin, mrin, rout;
  int n_fail = 0, num_checks = 0, k, ci;
  // Each row lasts one cycle; flags accumulate from row to row
  fcsw_row_t rows[9] = '{'{7'h01, 2'h0, 4'h0, 16'h0005}, '{7'h02, 2'h0, 4'h0, 16'h0007},
    '{7'h08, 2'h3, 4'h0, 16'h00C7}, '{7'h10, 2'h3, 4'hA, 16'h0AC7}, '{7'h40, 2'h3, 4'h5, 16'h5AC7},
    '{7'h20, 2'h3, 4'h0, 16'h50C7}, '{7'h04, 2'h3, 4'h0, 16'h00C4}, '{7'h75, 2'h3, 4'h9, 16'h99C5},
    '{7'h0C, 2'h1, 4'h0, 16'h0944}};

  always #2 clk = ~clk;

  fcsw_master_model u_master (.i_send(send), .i_ctrl_word(ctrl), .i_rio_want(want), .i_connected(conn),
    .o_frame_valid(fv), .o_command_tag(tag), .o_fault_clear_request(freq), .o_rio_in(mrin));
  fcsw_status_word #(.P_IN_CYC(P_IN), .P_OUT_CYC(P_OUT), .P_CLEAR_CYC(CLR)) uut (.i_clk_sys(clk),
    .i_reset(rst), .i_alarm_event(ev[0]), .i_warning_event(ev[1]), .i_alarm_clear_cmd(ev[2]),
    .i_cmd_busy(busy), .i_disconnect_cmd(disc), .i_frame_valid(fv), .i_command_tag(tag),
    .i_fault_clear_request(freq), .i_cmd_valid(ev[5]), .i_cmd_error_event(ev[4]), .i_cmd_error_code(code),
    .i_link_error_event(ev[6]), .i_link_error_code(code), .i_connection_on(pin), .i_rio_in(mrin),
    .i_rio_out_src(src), .o_status_word(sw), .o_disconnect_exec(dx), .o_connected(conn), .o_rio_in(rin),
    .o_rio_out(rout));

  // ----------------------------------------
  // Compare, wait and close
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait; selector picks the condition
  task automatic wait_on(input int s, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk) #1;
      cnt++;
      if (cnt > 200) begin
        n_fail++;
        finish_test();
      end
    end while (!(s == 0 ? sw[3] === 1'b1 : s == 1 ? conn === 1'b1 : s == 2 ? rin === want :
      s == 3 ? rout === src : conn === 1'b0));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check("reset sw", sw, 16'h0004);
    check("reset rin", rin, 16'h0000);
    foreach (rows[i]) begin
      {ev, send, ctrl[7:6], code} = {rows[i].ev, rows[i].ev[3], rows[i].tag, rows[i].code};
      @(posedge clk) #1;
      check("status", sw, rows[i].exp);
    end
    ev = 7'h00;
    send = 1'b0;
    $display("test rows done");
    // Disconnect while busy still runs at once
    busy = 1'b1;
    disc = 1'b1;
    #1 check("busy", sw, 16'h0940);
    @(posedge clk) #1;
    disc = 1'b0;
    check("disc", {15'h0, dx}, 16'h0001);
    @(posedge clk) #1;
    busy = 1'b0;
    check("disc end", {15'h0, dx}, 16'h0000);
    $display("test busy done");
    // Clearing with alarm, warning and link error pending
    ev = 7'h43;
    code = 4'h6;
    @(posedge clk) #1;
    ev = 7'h00;
    ctrl[3] = 1'b1;
    wait_on(0, k);
    check("clear time", 16'(k), 16'(CLR + 1));
    @(posedge clk) #1;
    check("cleared", sw, 16'h094C);
    ctrl[3] = 1'b0;
    @(posedge clk) #1;
    check("done drop", sw, 16'h0944);
    // Request withdrawn mid-process gives no completion and clears no alarm
    ctrl[3] = 1'b1;
    ev = 7'h01;
    repeat (2) @(posedge clk) #1;
    ev = 7'h00;
    ctrl[3] = 1'b0;
    repeat (8) @(posedge clk) #1;
    check("aborted", sw, 16'h0945);
    $display("test clear done");
    // Link-up: inputs open before outputs, both close on drop
    pin = 1'b1;
    wait_on(1, k);
    check("in closed", rin, 16'h0000);
    wait_on(2, ci);
    check("in lag", 16'(ci), 16'(P_IN + 1));
    wait_on(3, k);
    check("out lag", 16'(k), 16'(P_OUT - P_IN));
    pin = 1'b0;
    wait_on(4, k);
    @(posedge clk) #1;
    src = 16'h0F0F;
    repeat (3) @(posedge clk) #1;
    check("in off", rin, 16'h0000);
    check("out held", rout, 16'hA5A5);
    check("start off", mrin, 16'hFFFC);
    $display("test link done");
    // Reset in mid-run clears every flag and field except the accept flag, which follows busy
    ev = 7'h53;
    code = 4'h3;
    @(posedge clk) #1;
    ev = 7'h00;
    check("pre reset", sw, 16'h3347);
    rst = 1'b1;
    repeat (2) @(posedge clk) #1;
    rst = 1'b0;
    check("mid reset sw", sw, 16'h0004);
    check("mid reset out", rout, 16'h0000);
    @(posedge clk) #1;
    check("after reset sw", sw, 16'h0004);
    $display("test reset done");
    finish_test();
  end
endmodule
